// >>> rtl/pdm_pkg.sv
package pdm_pkg;
    localparam logic [3:0] SYS_CTRL_OFS = 4'h0;
    localparam logic [3:0] REQ_EN_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam int STANDBY_SELECT_BIT_POS = 7;
    localparam int STS_HI_POS = 6;
    localparam int STS_LO_POS = 4;
    localparam int NONMASKABLE_EDGE_SELECT_POS = 3;
    localparam int RAM_ENABLE_BIT_POS = 0;
    localparam int MODE_ERR_POS = 4;
    localparam logic [7:0] SYS_CTRL_INIT = 8'h09;
    localparam logic [7:0] SYS_CTRL_MASK = 8'hf9;
    localparam logic [2:0] REQ_EN_INIT = 3'h0;
    localparam int SETTLE_W = 18;
    localparam logic [SETTLE_W-1:0] SETTLE_BASE_STATES = 18'h02000;
    localparam int CRYSTAL_SETTLE_MS = 8;
    localparam int CLK_HZ = 40000000;
    localparam int CRYSTAL_SETTLE_CYCLES = (CLK_HZ / 1000) * CRYSTAL_SETTLE_MS;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_SW_STANDBY_PIN_N = 3'b010,
        ST_SETTLE = 3'b011,
        ST_HW_STANDBY_PIN_N = 3'b100,
        ST_CHIP_RST = 3'b101
    } pdm_state_e;
endpackage : pdm_pkg

// >>> rtl/power_down_mode_controller.sv
// Function
// - halt with select clear: sleep, core stops
// - sleep keeps peripherals clocked and running
// - enabled unmasked interrupt ends sleep
// - reset pin low in sleep: reset state
// - standby pin low in sleep: hardware standby
// - halt with select set: software standby
// - software standby resets all peripherals
// - wake request restarts oscillator, settle, interrupt
// - disabled or masked request keeps standby
// - reset pin ends software standby, no settling
// - settle field selects wake-up state count
// - edge select bit picks nonmaskable edge
// - software standby holds port drive states
// - standby pin low always: hardware standby
// - hardware standby floats all port pins
// - standby rise then reset rise: restart
// - select bit survives interrupt wake-up
`timescale 1ns/1ps
module power_down_mode_controller
    import pdm_pkg::*;
#(
    parameter logic [SETTLE_W-1:0] SETTLE_BASE = SETTLE_BASE_STATES
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic halt_exec_in,
    input wire logic irq_pending_in,
    input wire logic nonmaskable_pin_in,
    input wire logic nonmaskable_masked_in,
    input wire logic [2:0] external_request_n_in,
    input wire logic [2:0] external_masked_in,
    input wire logic chip_init_pin_n_in,
    input wire logic standby_pin_n_in,
    input wire logic [1:0] operating_mode_pins_in,
    output logic core_halt_out,
    output logic core_reset_out,
    output logic clock_run_out,
    output logic periph_clk_en_out,
    output logic periph_reset_out,
    output logic port_hold_out,
    output logic port_hiz_out,
    output logic ram_enable_out,
    output logic intr_exc_out,
    output logic reset_exc_out,
    output logic [2:0] state_out
);
    pdm_state_e state_reg;
    pdm_state_e state_next;
    logic [7:0] system_control_reg;
    logic [7:0] system_control_next;
    logic [2:0] req_enable_reg;
    logic [2:0] req_enable_next;
    logic nmi_prev_reg;
    logic mode_err_reg;
    logic mode_err_next;
    logic [1:0] mode_latch_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic core_halt_reg;
    logic core_reset_reg;
    logic clock_run_reg;
    logic periph_clk_reg;
    logic periph_reset_reg;
    logic port_hold_reg;
    logic port_hiz_reg;
    logic intr_exc_reg;
    logic reset_exc_reg;

    settle_if settle ();

    settle_counter #(
        .BASE_STATES(SETTLE_BASE)
    ) u_settle (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .port(settle)
    );

    function automatic logic is_stopped(input pdm_state_e st);
        is_stopped = (st == ST_SW_STANDBY_PIN_N) || (st == ST_SETTLE) ||
            (st == ST_HW_STANDBY_PIN_N);
    endfunction : is_stopped

    // field views
    wire standby_select_bit = system_control_reg[STANDBY_SELECT_BIT_POS];
    wire [2:0] settle_time_select =
        system_control_reg[STS_HI_POS:STS_LO_POS];
    wire nonmaskable_edge_select = system_control_reg[NONMASKABLE_EDGE_SELECT_POS];
    wire ram_enable_bit = system_control_reg[RAM_ENABLE_BIT_POS];

    // wake sources
    wire nmi_rise = nonmaskable_pin_in && !nmi_prev_reg;
    wire nmi_fall = !nonmaskable_pin_in && nmi_prev_reg;
    wire nmi_edge = nonmaskable_edge_select ? nmi_rise : nmi_fall;
    wire nmi_wake = nmi_edge && !nonmaskable_masked_in;
    wire ext_wake = |(~external_request_n_in & req_enable_reg &
        ~external_masked_in);
    wire sleep_wake = irq_pending_in || nmi_wake || ext_wake;
    wire standby_pin_n_wake = nmi_wake || ext_wake;

    // bus decode
    wire bus_req = avs_read_in || avs_write_in;
    wire bus_take = bus_req && !wait_reg;
    wire wr_lane0 = bus_take && avs_write_in && avs_byteenable_in[0];
    wire wr_ctrl = wr_lane0 && (avs_address_in == SYS_CTRL_OFS);
    wire wr_en = wr_lane0 && (avs_address_in == REQ_EN_OFS);
    wire wr_stat = wr_lane0 && (avs_address_in == STATUS_OFS);
    wire [31:0] status_word = {27'h0, mode_err_reg, 1'b0, state_reg};
    wire [31:0] rdata_sel =
        (avs_address_in == SYS_CTRL_OFS) ? {24'h0, system_control_reg} :
        (avs_address_in == REQ_EN_OFS) ? {29'h0, req_enable_reg} :
        (avs_address_in == STATUS_OFS) ? status_word : 32'h0;

    // mode pins moving during hardware standby
    wire mode_moved = (state_reg == ST_HW_STANDBY_PIN_N) &&
        (operating_mode_pins_in != mode_latch_reg);

    always_comb begin
        state_next = state_reg;
        if (!standby_pin_n_in) begin
            state_next = ST_HW_STANDBY_PIN_N;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (!chip_init_pin_n_in) begin
                        state_next = ST_CHIP_RST;
                    end else if (halt_exec_in && !standby_select_bit) begin
                        state_next = ST_SLEEP;
                    end else if (halt_exec_in) begin
                        state_next = ST_SW_STANDBY_PIN_N;
                    end
                end
                ST_SLEEP: begin
                    if (!chip_init_pin_n_in) begin
                        state_next = ST_CHIP_RST;
                    end else if (sleep_wake) begin
                        state_next = ST_RUN;
                    end
                end
                ST_SW_STANDBY_PIN_N: begin
                    if (!chip_init_pin_n_in) begin
                        state_next = ST_CHIP_RST;
                    end else if (standby_pin_n_wake) begin
                        state_next = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (!chip_init_pin_n_in) begin
                        state_next = ST_CHIP_RST;
                    end else if (settle.done) begin
                        state_next = ST_RUN;
                    end
                end
                ST_HW_STANDBY_PIN_N: begin
                    if (!chip_init_pin_n_in) begin
                        state_next = ST_CHIP_RST;
                    end
                end
                ST_CHIP_RST: begin
                    if (chip_init_pin_n_in) begin
                        state_next = ST_RUN;
                    end
                end
                default: begin
                    state_next = ST_CHIP_RST;
                end
            endcase
        end
    end

    assign settle.start = (state_reg == ST_SW_STANDBY_PIN_N) &&
        (state_next == ST_SETTLE);
    assign settle.sel = settle_time_select;

    // control register, reloaded with SYS_CTRL_INIT by chip reset and hardware standby
    always_comb begin
        system_control_next = system_control_reg;
        if (state_reg == ST_HW_STANDBY_PIN_N || state_reg == ST_CHIP_RST) begin
            system_control_next = SYS_CTRL_INIT;
        end else if (wr_ctrl) begin
            // only software writes and the SYS_CTRL_INIT reload move the select bit
            system_control_next = avs_writedata_in[7:0] &
                SYS_CTRL_MASK;
        end
    end

    assign req_enable_next = (state_reg == ST_HW_STANDBY_PIN_N ||
        state_reg == ST_CHIP_RST) ? REQ_EN_INIT :
        wr_en ? avs_writedata_in[2:0] : req_enable_reg;
    // a new mismatch wins over a clear in the same cycle
    assign mode_err_next = mode_moved ||
        (mode_err_reg && !(wr_stat && avs_writedata_in[MODE_ERR_POS]));

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_CHIP_RST;
            system_control_reg <= SYS_CTRL_INIT;
            req_enable_reg <= REQ_EN_INIT;
            nmi_prev_reg <= 1'b0;
            mode_err_reg <= 1'b0;
            mode_latch_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            system_control_reg <= system_control_next;
            req_enable_reg <= req_enable_next;
            nmi_prev_reg <= nonmaskable_pin_in;
            mode_err_reg <= mode_err_next;
            if (state_reg != ST_HW_STANDBY_PIN_N) begin
                mode_latch_reg <= operating_mode_pins_in;
            end
        end
    end

    // one wait state, then a one-cycle answer
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= !(bus_req && wait_reg);
            rdata_reg <= (bus_req && wait_reg && avs_read_in) ?
                rdata_sel : rdata_reg;
        end
    end

    // outputs follow the next state so they line up with state_reg
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            core_halt_reg <= 1'b1;
            core_reset_reg <= 1'b1;
            clock_run_reg <= 1'b1;
            periph_clk_reg <= 1'b1;
            periph_reset_reg <= 1'b1;
            port_hold_reg <= 1'b0;
            port_hiz_reg <= 1'b0;
            intr_exc_reg <= 1'b0;
            reset_exc_reg <= 1'b0;
        end else begin
            core_halt_reg <= state_next != ST_RUN;
            core_reset_reg <= state_next == ST_CHIP_RST ||
                state_next == ST_HW_STANDBY_PIN_N;
            clock_run_reg <= !is_stopped(state_next);
            periph_clk_reg <= !is_stopped(state_next);
            periph_reset_reg <= is_stopped(state_next) ||
                state_next == ST_CHIP_RST;
            port_hold_reg <= state_next == ST_SW_STANDBY_PIN_N ||
                state_next == ST_SETTLE;
            port_hiz_reg <= state_next == ST_HW_STANDBY_PIN_N;
            intr_exc_reg <= state_next == ST_RUN &&
                (state_reg == ST_SLEEP ||
                state_reg == ST_SETTLE);
            reset_exc_reg <= state_next == ST_RUN &&
                state_reg == ST_CHIP_RST;
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign core_halt_out = core_halt_reg;
    assign core_reset_out = core_reset_reg;
    assign clock_run_out = clock_run_reg;
    assign periph_clk_en_out = periph_clk_reg;
    assign periph_reset_out = periph_reset_reg;
    assign port_hold_out = port_hold_reg;
    assign port_hiz_out = port_hiz_reg;
    assign ram_enable_out = ram_enable_bit;
    assign intr_exc_out = intr_exc_reg;
    assign reset_exc_out = reset_exc_reg;
    assign state_out = state_reg;

    sleep_entry_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_RUN && halt_exec_in && !standby_select_bit &&
        standby_pin_n_in && chip_init_pin_n_in
        |=> state_reg == ST_SLEEP && core_halt_out)
        else $error("halt did not enter sleep");

    sleep_periph_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_SLEEP |-> periph_clk_en_out && !periph_reset_out &&
        clock_run_out)
        else $error("peripherals stopped in sleep");

    sleep_wake_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_SLEEP && sleep_wake && standby_pin_n_in &&
        chip_init_pin_n_in |=> intr_exc_out ##1 !intr_exc_out)
        else $error("sleep wake without one interrupt pulse");

    reset_pin_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        (state_reg == ST_SLEEP || state_reg == ST_SW_STANDBY_PIN_N) &&
        !chip_init_pin_n_in && standby_pin_n_in
        |=> state_reg == ST_CHIP_RST && clock_run_out)
        else $error("reset pin did not reach reset state");

    hw_entry_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        !standby_pin_n_in |=> state_reg == ST_HW_STANDBY_PIN_N && port_hiz_out &&
        periph_reset_out && !clock_run_out)
        else $error("standby pin did not enter hardware standby");

    sw_entry_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_RUN && halt_exec_in && standby_select_bit &&
        standby_pin_n_in && chip_init_pin_n_in
        |=> periph_reset_out && port_hold_out && !clock_run_out)
        else $error("software standby entry wrong");

    standby_pin_n_stay_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_SW_STANDBY_PIN_N && !nmi_wake && !ext_wake &&
        standby_pin_n_in && chip_init_pin_n_in |=> state_reg == ST_SW_STANDBY_PIN_N)
        else $error("left standby without a wake request");

    select_keep_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_SETTLE && state_next == ST_RUN
        |=> standby_select_bit && $stable(system_control_reg))
        else $error("select bit lost on wake-up");

    edge_sel_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        state_reg == ST_SW_STANDBY_PIN_N && !nonmaskable_masked_in && !ext_wake &&
        standby_pin_n_in && chip_init_pin_n_in &&
        $past(nonmaskable_pin_in) == nonmaskable_edge_select &&
        nonmaskable_pin_in == nonmaskable_edge_select
        |=> state_reg == ST_SW_STANDBY_PIN_N)
        else $error("standby left without the selected edge");
endmodule : power_down_mode_controller

// >>> rtl/settle_counter.sv
`timescale 1ns/1ps
module settle_counter
    import pdm_pkg::*;
#(
    parameter logic [SETTLE_W-1:0] BASE_STATES = SETTLE_BASE_STATES
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    settle_if.cnt port
);
    logic [SETTLE_W-1:0] count_reg;
    logic [SETTLE_W-1:0] count_next;
    logic done_reg;
    logic [SETTLE_W-1:0] load_value;

    // 10x and the illegal 11x both give the longest wait
    function automatic logic [SETTLE_W-1:0] settle_states(
        input logic [2:0] sel
    );
        if (sel[2]) begin
            settle_states = BASE_STATES << 4;
        end else begin
            settle_states = BASE_STATES << sel[1:0];
        end
    endfunction : settle_states

    assign load_value = settle_states(port.sel);
    assign count_next = port.start ? load_value :
        (count_reg != '0) ? count_reg - 1'b1 : count_reg;
    assign port.done = done_reg;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= !port.start && (count_reg == 18'h00001);
        end
    end

    settle_done_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        port.done |-> $past(count_reg) == 18'h00001)
        else $error("settle done without full count");
endmodule : settle_counter

// >>> rtl/settle_if.sv
`timescale 1ns/1ps
interface settle_if;
    logic start;
    logic [2:0] sel;
    logic done;
    modport ctrl (output start, output sel, input done);
    modport cnt (input start, input sel, output done);
endinterface : settle_if

// >>> testbench/core_board_model.sv
`timescale 1ns/1ps
module core_board_model (
    input wire logic clk_sys_in,
    output logic halt_out,
    output logic irq_out,
    output logic nmi_out,
    output logic nmi_masked_out,
    output logic [2:0] ext_n_out,
    output logic [2:0] ext_masked_out,
    output logic init_n_out,
    output logic standby_n_out,
    output logic [1:0] mode_out
);
    initial begin
        halt_out = 1'b0;
        irq_out = 1'b0;
        nmi_out = 1'b1;
        nmi_masked_out = 1'b0;
        ext_n_out = 3'h7;
        ext_masked_out = 3'h0;
        init_n_out = 1'b1;
        standby_n_out = 1'b1;
        mode_out = 2'h2; // mode pins held at 2 until the testbench drives mode_out
    end
    task automatic halt_core();
        @(posedge clk_sys_in);
        halt_out <= 1'b1;
        @(posedge clk_sys_in);
        halt_out <= 1'b0;
    endtask : halt_core
    task automatic set_wake(input logic irq, input logic nmi,
        input logic nmi_m, input logic [2:0] ext_n, input logic [2:0] ext_m);
        @(posedge clk_sys_in);
        irq_out <= irq;
        nmi_out <= nmi;
        nmi_masked_out <= nmi_m;
        ext_n_out <= ext_n;
        ext_masked_out <= ext_m;
    endtask : set_wake
    task automatic set_pins(input logic init_n, input logic standby_pin_n_n);
        @(posedge clk_sys_in);
        init_n_out <= init_n;
        standby_n_out <= standby_pin_n_n;
    endtask : set_pins
    task automatic hw_enter(); // reset pin low before standby pin
        set_pins(1'b0, 1'b1);
        repeat (2) @(posedge clk_sys_in);
        standby_n_out <= 1'b0;
    endtask : hw_enter
    task automatic hw_exit(input int settle);
        set_pins(1'b0, 1'b0);
        set_pins(1'b0, 1'b1);
        repeat (settle) @(posedge clk_sys_in); // reset held
        init_n_out <= 1'b1; // reset rise restarts the core
    endtask : hw_exit
endmodule : core_board_model

// >>> testbench/power_down_mode_controller_tb_top.sv
`timescale 1ns/1ps
module power_down_mode_controller_tb_top;
    import pdm_pkg::*;
    localparam logic [SETTLE_W-1:0] SB = 18'h00004;
    logic clk_sys_in, reset_n_in, avs_read_in, avs_write_in;
    logic [3:0] avs_address_in, avs_byteenable_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rdummy;
    logic avs_waitrequest_out, halt_exec_in, irq_pending_in;
    logic nonmaskable_pin_in, nonmaskable_masked_in;
    logic [2:0] external_request_n_in, external_masked_in, state_out;
    logic chip_init_pin_n_in, standby_pin_n_in;
    logic [1:0] operating_mode_pins_in;
    logic core_halt_out, core_reset_out, clock_run_out, periph_clk_en_out;
    logic periph_reset_out, port_hold_out, port_hiz_out, ram_enable_out;
    logic intr_exc_out, reset_exc_out;
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    logic [SETTLE_W-1:0] exp_n;
    power_down_mode_controller #(.SETTLE_BASE(SB)) power_down_mode_controller_i (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .halt_exec_in(halt_exec_in), .irq_pending_in(irq_pending_in),
        .nonmaskable_pin_in(nonmaskable_pin_in),
        .nonmaskable_masked_in(nonmaskable_masked_in),
        .external_request_n_in(external_request_n_in),
        .external_masked_in(external_masked_in),
        .chip_init_pin_n_in(chip_init_pin_n_in),
        .standby_pin_n_in(standby_pin_n_in),
        .operating_mode_pins_in(operating_mode_pins_in),
        .core_halt_out(core_halt_out), .core_reset_out(core_reset_out),
        .clock_run_out(clock_run_out), .periph_clk_en_out(periph_clk_en_out),
        .periph_reset_out(periph_reset_out), .port_hold_out(port_hold_out),
        .port_hiz_out(port_hiz_out), .ram_enable_out(ram_enable_out),
        .intr_exc_out(intr_exc_out), .reset_exc_out(reset_exc_out),
        .state_out(state_out));
    core_board_model core_board_model_i (
        .clk_sys_in(clk_sys_in), .halt_out(halt_exec_in),
        .irq_out(irq_pending_in), .nmi_out(nonmaskable_pin_in),
        .nmi_masked_out(nonmaskable_masked_in),
        .ext_n_out(external_request_n_in),
        .ext_masked_out(external_masked_in),
        .init_n_out(chip_init_pin_n_in), .standby_n_out(standby_pin_n_in),
        .mode_out(operating_mode_pins_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic fail(input string msg);
        n_mismatch++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : fail
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask : check_word
    // halt, reset, clock, periph clock, periph reset, hold, float
    function automatic logic [6:0] exp_outs(input pdm_state_e s);
        case (s)
            ST_RUN: return 7'b0011000;
            ST_SLEEP: return 7'b1011000; // peripherals run
            ST_SW_STANDBY_PIN_N, ST_SETTLE: return 7'b1000110;
            ST_HW_STANDBY_PIN_N: return 7'b1100101;
            ST_CHIP_RST: return 7'b1111100; // clock on at once
            default: return 7'b0000000;
        endcase
    endfunction : exp_outs
    task automatic check_mode(input pdm_state_e s);
        logic [9:0] got;
        got = {state_out, core_halt_out, core_reset_out, clock_run_out,
            periph_clk_en_out, periph_reset_out, port_hold_out, port_hiz_out};
        checks_done++;
        if (got !== {s, exp_outs(s)}) fail($sformatf("mode %b in %0d", got, s));
    endtask : check_mode
    task automatic wait_state(input pdm_state_e s, input int lim);
        int k;
        k = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            k++;
        end while (state_out !== s && k < lim);
        if (state_out !== s) fail("state not reached");
    endtask : wait_state
    task automatic stay(input pdm_state_e s);
        repeat (5) @(posedge clk_sys_in);
        #1;
        check_mode(s);
    endtask : stay
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [7:0] d, input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk_sys_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h000000, d};
        avs_byteenable_in <= be;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        @(posedge clk_sys_in);
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge clk_sys_in);
        end
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1, rdummy);
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00, 4'h1, rdummy);
        check_word(rdummy, exp);
    endtask : rd_chk
    task automatic enter(input logic [7:0] ctl, input pdm_state_e s);
        wr(SYS_CTRL_OFS, ctl);
        core_board_model_i.halt_core();
        wait_state(s, 4);
        check_mode(s);
    endtask : enter
    initial begin
        repeat (40000) @(posedge clk_sys_in);
        fail("watchdog expired");
        finish_test();
    end
    initial begin
        reset_n_in = 1'b0;
        avs_address_in = 4'h0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h00000000;
        avs_byteenable_in = 4'h1;
        repeat (3) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        wait_state(ST_RUN, 6);
        check_word({31'h0, reset_exc_out}, 32'h1);
        rd_chk(SYS_CTRL_OFS, 32'h09);
        rd_chk(REQ_EN_OFS, 32'h0);
        rd_chk(4'hc, 32'h0);
        bus(1'b1, SYS_CTRL_OFS, 8'hff, 4'h0, rdummy);
        rd_chk(SYS_CTRL_OFS, 32'h09);
        wr(SYS_CTRL_OFS, 8'hff);
        rd_chk(SYS_CTRL_OFS, 32'hf9);
        enter(8'h00, ST_SLEEP);
        core_board_model_i.set_wake(1'b0, 1'b0, 1'b1, 3'h6, 3'h0);
        stay(ST_SLEEP);
        core_board_model_i.set_wake(1'b1, 1'b1, 1'b0, 3'h7, 3'h0);
        wait_state(ST_RUN, 4);
        check_word({31'h0, intr_exc_out}, 32'h1);
        core_board_model_i.set_wake(1'b0, 1'b1, 1'b0, 3'h7, 3'h0);
        enter(8'h00, ST_SLEEP);
        core_board_model_i.set_pins(1'b0, 1'b1);
        wait_state(ST_CHIP_RST, 4);
        check_mode(ST_CHIP_RST);
        core_board_model_i.set_pins(1'b1, 1'b1);
        wait_state(ST_RUN, 4);
        check_word({31'h0, reset_exc_out}, 32'h1);
        enter(8'h00, ST_SLEEP);
        core_board_model_i.set_pins(1'b1, 1'b0);
        wait_state(ST_HW_STANDBY_PIN_N, 4);
        check_mode(ST_HW_STANDBY_PIN_N);
        core_board_model_i.hw_exit(8);
        wait_state(ST_RUN, 20);
        check_word({31'h0, reset_exc_out}, 32'h1);
        // bench clock counts as external: every settle value
        for (int sel = 0; sel < 8; sel++) begin
            n = sel % 3;
            exp_n = sel[2] ? (SB << 4) : (SB << sel[1:0]);
            wr(REQ_EN_OFS, 8'h01 << n);
            enter({1'b1, 3'(sel), 4'h9}, ST_SW_STANDBY_PIN_N);
            core_board_model_i.set_wake(1'b1, 1'b1, 1'b0, 3'h0, 3'h1 << n);
            stay(ST_SW_STANDBY_PIN_N);
            core_board_model_i.set_wake(1'b1, 1'b1, 1'b0, 3'h0, 3'h0);
            wait_state(ST_SETTLE, 4);
            check_mode(ST_SETTLE);
            n = 0;
            while (state_out === ST_SETTLE && n < 200) begin
                @(posedge clk_sys_in);
                #1;
                n++;
            end
            check_word(32'(n), 32'(exp_n) + 32'h1);
            check_mode(ST_RUN);
            check_word({31'h0, intr_exc_out}, 32'h1);
            core_board_model_i.set_wake(1'b0, 1'b1, 1'b0, 3'h7, 3'h0);
            rd_chk(SYS_CTRL_OFS, {24'h0, 1'b1, 3'(sel), 4'h9});
        end
        wr(REQ_EN_OFS, 8'h00);
        for (int e = 0; e < 2; e++) begin
            core_board_model_i.set_wake(1'b0, e[0], 1'b0, 3'h7, 3'h0);
            enter({4'h8, e[0], 3'h1}, ST_SW_STANDBY_PIN_N);
            core_board_model_i.set_wake(1'b0, !e[0], 1'b0, 3'h7, 3'h0);
            stay(ST_SW_STANDBY_PIN_N);
            core_board_model_i.set_wake(1'b0, e[0], 1'b1, 3'h7, 3'h0);
            stay(ST_SW_STANDBY_PIN_N);
            core_board_model_i.set_wake(1'b0, !e[0], 1'b0, 3'h7, 3'h0);
            core_board_model_i.set_wake(1'b0, e[0], 1'b0, 3'h7, 3'h0);
            wait_state(ST_SETTLE, 4);
            check_mode(ST_SETTLE);
            wait_state(ST_RUN, 20);
            check_word({31'h0, intr_exc_out}, 32'h1);
        end
        enter(8'h89, ST_SW_STANDBY_PIN_N);
        core_board_model_i.set_pins(1'b0, 1'b1);
        wait_state(ST_CHIP_RST, 3);
        check_mode(ST_CHIP_RST);
        core_board_model_i.set_pins(1'b1, 1'b1);
        wait_state(ST_RUN, 4);
        check_word({31'h0, reset_exc_out}, 32'h1);
        core_board_model_i.hw_enter();
        wait_state(ST_HW_STANDBY_PIN_N, 8);
        check_mode(ST_HW_STANDBY_PIN_N);
        core_board_model_i.hw_exit(8);
        wait_state(ST_RUN, 20);
        enter(8'h88, ST_SW_STANDBY_PIN_N);
        check_word({31'h0, ram_enable_out}, 32'h0);
        core_board_model_i.set_pins(1'b1, 1'b0);
        wait_state(ST_HW_STANDBY_PIN_N, 4);
        check_mode(ST_HW_STANDBY_PIN_N);
        wr(SYS_CTRL_OFS, 8'h80);
        rd_chk(STATUS_OFS, 32'h04);
        @(posedge clk_sys_in);
        core_board_model_i.mode_out <= 2'h1;
        rd_chk(STATUS_OFS, 32'h14);
        core_board_model_i.hw_exit(8);
        wait_state(ST_RUN, 20);
        check_word({31'h0, reset_exc_out}, 32'h1);
        rd_chk(SYS_CTRL_OFS, 32'h09);
        wr(STATUS_OFS, 8'h10);
        rd_chk(STATUS_OFS, 32'h00);
        finish_test();
    end
endmodule : power_down_mode_controller_tb_top
